//--- flr_defines.svh
// Constants of the fault history logger: codes, byte positions, timing
// Assumes inclusion by bare name in every file that needs a number
`ifndef FLR_DEFINES_SVH
`define FLR_DEFINES_SVH
// Command codes
`define FLR_CMD_READOUT 8'hEE
`define FLR_CMD_STORE 8'hEA
`define FLR_CMD_ERASE 8'hEC
// Block layout
`define FLR_LOG_LEN 8'h93
`define FLR_LAST_IDX 8'h92
`define FLR_POS_FAULT 8'h00
`define FLR_POS_TIME_LO 8'h01
`define FLR_POS_TIME_HI 8'h06
`define FLR_POS_VPK_HI 8'h07
`define FLR_POS_VPK_LO 8'h08
`define FLR_POS_IPK_HI 8'h0B
`define FLR_POS_IPK_LO 8'h0C
`define FLR_PAGE_BASE 8'h1B
`define FLR_PAGE_LAST_OFF 5'h13
`define FLR_PAGE_COUNT 6
`define FLR_PAGE_LAST 3'h5
`define FLR_PAGE_KEEP 3'h3
`define FLR_OFF_VOUT_HI 5'h00
`define FLR_OFF_VOUT_LO 5'h01
`define FLR_OFF_IOUT_HI 5'h04
`define FLR_OFF_IOUT_LO 5'h05
// Status and configuration bits
`define FLR_STAT_STORE_BIT 3
`define FLR_CFG_LOG_EN_BIT 7
`define FLR_STORE_CODE 8'hFF
// Temperature limits in degrees C
`define FLR_TEMP_OFF_C 8'h82
`define FLR_TEMP_ON_C 8'h7D
// Timing
`define FLR_TICK_NS 200000
`define FLR_CLK_NS 25
`define FLR_TICK_CYCLES (`FLR_TICK_NS / `FLR_CLK_NS)
`endif

//--- flr_pkg.sv
// Types of the fault history logger
// Assumes nothing beyond a SystemVerilog compiler
package flr_pkg;
    typedef enum logic [2:0] {
        FLR_IDLE = 3'h1,
        FLR_LEN = 3'h2,
        FLR_DATA = 3'h4
    } flr_state_type;
    typedef struct packed {
        logic [15:0] vout;
        logic [15:0] iout;
    } flr_page_type;
endpackage

//--- flr_nvm_if.sv
// Link between the capture logic and the retained history store
// Assumes one clock shared by both ends
`timescale 1ns/1ps
`include "flr_defines.svh"
interface flr_nvm_if;
    logic commit;
    logic erase;
    logic [7:0] faultCode;
    logic [47:0] upTime;
    logic [15:0] vPeak;
    logic [15:0] iPeak;
    flr_pkg::flr_page_type pages [`FLR_PAGE_COUNT];
    logic [7:0] rdIdx;
    logic [2:0] rdPage;
    logic [4:0] rdOff;
    logic [7:0] rdByte;
    logic present;
    logic locked;
    modport ctrl (
        output commit, erase, faultCode, upTime, vPeak, iPeak, pages,
        output rdIdx, rdPage, rdOff,
        input rdByte, present, locked
    );
    modport store (
        input commit, erase, faultCode, upTime, vPeak, iPeak, pages,
        input rdIdx, rdPage, rdOff,
        output rdByte, present, locked
    );
endinterface

//--- flr_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
// Assumes one clock; contents are not reset, only the pointers and the count
`timescale 1ns/1ps
module flr_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    wire [AW-1:0] wrPtr_nxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
    wire [AW-1:0] rdPtr_nxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
    assign inReady = (count_r != (AW + 1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_nxt;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_nxt;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

//--- flr_history_store.sv
// Retained history image and its byte read port
// Assumes retainRst_n falls only when the retained supply is lost
`timescale 1ns/1ps
`include "flr_defines.svh"
module flr_history_store (
    // Clock and retention reset
    input wire logic core_clk,
    input wire logic retainRst_n,
    // Capture side
    flr_nvm_if.store nvm
);
    flr_pkg::flr_page_type pageMem [`FLR_PAGE_COUNT];
    flr_pkg::flr_page_type curPage;
    logic [7:0] faultCode_r;
    logic [47:0] upTime_r;
    logic [15:0] vPeak_r;
    logic [15:0] iPeak_r;
    logic present_r;
    logic locked_r;
    // ==========================================
    // Flags
    always_ff @(posedge core_clk or negedge retainRst_n) begin
        if (!retainRst_n) begin
            present_r <= 1'b0;
            locked_r <= 1'b0;
        end else if (nvm.erase) begin
            present_r <= 1'b0; // see RULE_03
            locked_r <= 1'b0;
        end else if (nvm.commit) begin
            present_r <= 1'b1; // see RULE_11
            locked_r <= 1'b1; // see RULE_17
        end
    end
    // ==========================================
    // Image
    always_ff @(posedge core_clk) begin
        if (nvm.commit) begin
            faultCode_r <= nvm.faultCode;
            upTime_r <= nvm.upTime;
            vPeak_r <= nvm.vPeak;
            iPeak_r <= nvm.iPeak;
        end
    end
    for (genvar k = 0; k < `FLR_PAGE_COUNT; k++) begin : g_page
        always_ff @(posedge core_clk) begin
            if (nvm.commit) begin
                pageMem[k] <= nvm.pages[k]; // see RULE_06
            end
        end
    end
    // ==========================================
    // Byte read port
    wire [7:0] idx = nvm.rdIdx;
    wire [2:0] timeSel = 3'(idx - `FLR_POS_TIME_LO);
    wire inTime = (idx >= `FLR_POS_TIME_LO) && (idx <= `FLR_POS_TIME_HI);
    wire inPages = (idx >= `FLR_PAGE_BASE);
    assign curPage = pageMem[nvm.rdPage];
    wire [7:0] pageByte = (nvm.rdOff == `FLR_OFF_VOUT_HI) ? curPage.vout[15:8] :
                          (nvm.rdOff == `FLR_OFF_VOUT_LO) ? curPage.vout[7:0] :
                          (nvm.rdOff == `FLR_OFF_IOUT_HI) ? curPage.iout[15:8] :
                          (nvm.rdOff == `FLR_OFF_IOUT_LO) ? curPage.iout[7:0] : 8'h00;
    assign nvm.rdByte = (idx == `FLR_POS_FAULT) ? faultCode_r : // see RULE_13
                        inTime ? upTime_r[{timeSel, 3'h0} +: 8] : // see RULE_14
                        (idx == `FLR_POS_VPK_HI) ? vPeak_r[15:8] : // see RULE_15
                        (idx == `FLR_POS_VPK_LO) ? vPeak_r[7:0] :
                        (idx == `FLR_POS_IPK_HI) ? iPeak_r[15:8] : // see RULE_16
                        (idx == `FLR_POS_IPK_LO) ? iPeak_r[7:0] :
                        inPages ? pageByte : 8'h00;
    assign nvm.present = present_r;
    assign nvm.locked = locked_r;
endmodule

//--- flr_capture_readout.sv
// Fault history capture and block readout, top level
// Inputs come from logic on core_clk; retainRst_n clears only the
// retained log flags and outlives arst_n
//
// Overview of operation
// RULE_01: Code EE streams the stored history bytes
// RULE_02: Code EA stores RAM history, faults output off
// RULE_03: Code EC erases history and drops lock
// RULE_04: No history: length byte zero, no data
// RULE_05: History present: length always 147 bytes
// RULE_06: Enabled fault stores header plus six pages
// RULE_07: Before reset newest page sits first
// RULE_08: After reset newest page position undefined
// RULE_09: Enabled forced store sets status bit three
// RULE_10: Store ignored above 130C until below 125C
// RULE_11: History readable after fault, kept until erase
// RULE_12: Early fault may leave older pages unfilled
// RULE_13: Byte 0 holds triggering fault code
// RULE_14: Bytes 1-6 uptime in 200us, LSB first
// RULE_15: Bytes 7-8 voltage peak high first; 9-10 zero
// RULE_16: Bytes 11-12 current peak high first
// RULE_17: Written history locked against automatic overwrite
// RULE_18: Pages five, six repeat fourth after reset
// RULE_19: Bytes stream ascending from length byte
`timescale 1ns/1ps
`include "flr_defines.svh"
module flr_capture_readout #(
    parameter int TICK_CYCLES = `FLR_TICK_CYCLES,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and resets
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic retainRst_n,
    // Command port
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic cmdRead,
    output logic cmdReady,
    // Readout stream
    output logic rdValid,
    output logic [7:0] rdData,
    output logic rdLast,
    input wire logic rdReady,
    // Telemetry
    input wire logic faultEvent,
    input wire logic [7:0] faultCode,
    input wire logic pageDone,
    input wire logic [15:0] voutReading,
    input wire logic [15:0] ioutReading,
    input wire logic peakClear,
    input wire logic [7:0] dieTempC,
    input wire logic [7:0] configAll,
    input wire logic statusClear,
    // Status
    output logic [7:0] vendorStatusFlags,
    output logic pwmFaultOff,
    output logic logPresent,
    output logic logLocked
);
    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    flr_nvm_if nvm ();

    flr_pkg::flr_state_type state_r;
    flr_pkg::flr_state_type state_nxt;
    flr_pkg::flr_page_type pageRing [`FLR_PAGE_COUNT];
    logic [2:0] wrSlot_r;
    logic [TW-1:0] tickCnt_r;
    logic [47:0] upTime_r;
    logic [15:0] vPeak_r;
    logic [15:0] iPeak_r;
    logic hot_r;
    logic fromNvm_r;
    logic [7:0] byteIdx_r;
    logic [2:0] pageIdx_r;
    logic [4:0] pageOff_r;
    logic [7:0] vendorStatus_r;
    logic cmdReady_r;
    logic pwmFaultOff_r;
    logic logPresent_r;
    logic logLocked_r;
    logic rdValid_r;
    logic [7:0] rdData_r;
    logic rdLast_r;
    logic fifoInValid;
    logic fifoInReady;
    logic [8:0] fifoIn;
    logic fifoOutValid;
    logic [8:0] fifoOut;

    // ==========================================
    // Helpers
    function automatic logic [2:0] ringSlot(input logic [2:0] base, input logic [2:0] back);
        logic [3:0] s;
        s = {1'b0, base} + 4'h5 - {1'b0, back};
        ringSlot = (s >= 4'(`FLR_PAGE_COUNT)) ? 3'(s - 4'(`FLR_PAGE_COUNT)) : s[2:0];
    endfunction

    function automatic logic [41:0] lin11Mag(input logic [15:0] w);
        logic [41:0] m;
        logic [5:0] sh;
        m = w[10] ? 42'h0 : {32'h0, w[9:0]};
        sh = {1'b0, ~w[15], w[14:11]};
        lin11Mag = m << sh;
    endfunction

    // ==========================================
    // Command decode
    wire cmdTake = cmdValid && cmdReady_r;
    wire readCmd = cmdTake && cmdRead && (cmdCode == `FLR_CMD_READOUT); // see RULE_01
    wire storeCmd = cmdTake && !cmdRead && (cmdCode == `FLR_CMD_STORE);
    wire eraseCmd = cmdTake && !cmdRead && (cmdCode == `FLR_CMD_ERASE); // see RULE_03
    wire logEnable = configAll[`FLR_CFG_LOG_EN_BIT];
    wire storeOk = storeCmd && !hot_r; // see RULE_10
    wire autoOk = faultEvent && !nvm.locked; // see RULE_17
    wire commitReq = (autoOk || storeOk) && logEnable && !eraseCmd; // see RULE_02, RULE_06

    // ==========================================
    // Temperature gate
    wire hot_nxt = (dieTempC > `FLR_TEMP_OFF_C) ? 1'b1 :
                   (dieTempC < `FLR_TEMP_ON_C) ? 1'b0 : hot_r; // see RULE_10

    // ==========================================
    // Uptime
    wire tick = (tickCnt_r == TW'(TICK_CYCLES - 1));
    wire [TW-1:0] tickCnt_nxt = tick ? '0 : tickCnt_r + 1'b1;
    wire [47:0] upTime_nxt = tick ? upTime_r + 48'h1 : upTime_r; // see RULE_14

    // ==========================================
    // Peaks
    wire vPeakUp = pageDone && (voutReading > vPeak_r);
    wire iPeakUp = pageDone && (lin11Mag(ioutReading) > lin11Mag(iPeak_r));
    wire [15:0] vPeak_nxt = peakClear ? 16'h0 : vPeakUp ? voutReading : vPeak_r;
    wire [15:0] iPeak_nxt = peakClear ? 16'h0 : iPeakUp ? ioutReading : iPeak_r;

    // ==========================================
    // Event page ring, newest first toward the store
    wire [2:0] wrSlot_nxt = !pageDone ? wrSlot_r :
                            (wrSlot_r == `FLR_PAGE_LAST) ? 3'h0 : wrSlot_r + 3'h1;
    always_ff @(posedge core_clk) begin
        if (pageDone) begin
            pageRing[wrSlot_r] <= {voutReading, ioutReading}; // see RULE_12
        end
    end
    for (genvar k = 0; k < `FLR_PAGE_COUNT; k++) begin : g_pages
        assign nvm.pages[k] = pageRing[ringSlot(wrSlot_r, 3'(k))]; // see RULE_07
    end

    // ==========================================
    // Store link
    assign nvm.commit = commitReq;
    assign nvm.erase = eraseCmd;
    assign nvm.faultCode = storeOk ? `FLR_STORE_CODE : faultCode; // see RULE_13
    assign nvm.upTime = upTime_r;
    assign nvm.vPeak = vPeak_r; // see RULE_15
    assign nvm.iPeak = iPeak_r; // see RULE_16
    assign nvm.rdIdx = byteIdx_r;
    assign nvm.rdOff = pageOff_r;
    assign nvm.rdPage = (fromNvm_r && (pageIdx_r > `FLR_PAGE_KEEP)) ?
                        `FLR_PAGE_KEEP : pageIdx_r; // see RULE_08, RULE_18

    flr_history_store u_store (
        .core_clk(core_clk),
        .retainRst_n(retainRst_n),
        .nvm(nvm.store)
    );

    // ==========================================
    // Readout sequencer
    wire lastByte = (byteIdx_r == `FLR_LAST_IDX);
    wire fifoPush = fifoInValid && fifoInReady;
    wire inPages = (byteIdx_r >= `FLR_PAGE_BASE);
    wire pageWrap = (pageOff_r == `FLR_PAGE_LAST_OFF);

    always_comb begin
        state_nxt = state_r;
        fifoInValid = 1'b0;
        fifoIn = 9'h000;
        case (state_r)
            flr_pkg::FLR_IDLE: begin
                if (readCmd) begin
                    state_nxt = flr_pkg::FLR_LEN;
                end
            end
            flr_pkg::FLR_LEN: begin
                fifoInValid = 1'b1;
                fifoIn = nvm.present ? {1'b0, `FLR_LOG_LEN} : 9'h100; // see RULE_04, RULE_05
                if (fifoInReady) begin
                    state_nxt = nvm.present ? flr_pkg::FLR_DATA : flr_pkg::FLR_IDLE;
                end
            end
            flr_pkg::FLR_DATA: begin
                fifoInValid = 1'b1;
                fifoIn = {lastByte, nvm.rdByte}; // see RULE_19
                if (fifoInReady && lastByte) begin
                    state_nxt = flr_pkg::FLR_IDLE;
                end
            end
            default: begin
                state_nxt = flr_pkg::FLR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            byteIdx_r <= 8'h00;
            pageIdx_r <= 3'h0;
            pageOff_r <= 5'h00;
        end else if (state_r == flr_pkg::FLR_LEN) begin
            byteIdx_r <= 8'h00;
            pageIdx_r <= 3'h0;
            pageOff_r <= 5'h00;
        end else if (fifoPush) begin
            byteIdx_r <= byteIdx_r + 8'h01; // see RULE_19
            if (inPages) begin
                pageOff_r <= pageWrap ? 5'h00 : pageOff_r + 5'h01;
                pageIdx_r <= pageWrap ? pageIdx_r + 3'h1 : pageIdx_r;
            end
        end
    end

    // ==========================================
    // Buffer and output stage
    wire fifoOutReady = !rdValid_r || rdReady;
    wire outLoad = fifoOutValid && fifoOutReady;

    flr_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOut)
    );

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdValid_r <= 1'b0;
            rdData_r <= 8'h00;
            rdLast_r <= 1'b0;
        end else if (outLoad) begin
            rdValid_r <= 1'b1;
            rdData_r <= fifoOut[7:0];
            rdLast_r <= fifoOut[8];
        end else if (rdReady) begin
            rdValid_r <= 1'b0;
        end
    end

    // ==========================================
    // Status
    logic [7:0] status_nxt;
    always_comb begin
        status_nxt = vendorStatus_r;
        if (storeOk && logEnable) begin
            status_nxt[`FLR_STAT_STORE_BIT] = 1'b1; // see RULE_09
        end else if (statusClear) begin
            status_nxt[`FLR_STAT_STORE_BIT] = 1'b0;
        end
    end

    // ==========================================
    // State registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= flr_pkg::FLR_IDLE;
            cmdReady_r <= 1'b1;
            wrSlot_r <= 3'h0;
            tickCnt_r <= '0;
            upTime_r <= 48'h0;
            vPeak_r <= 16'h0;
            iPeak_r <= 16'h0;
            hot_r <= 1'b0;
            fromNvm_r <= 1'b1;
            vendorStatus_r <= 8'h00;
            pwmFaultOff_r <= 1'b0;
            logPresent_r <= 1'b0;
            logLocked_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmdReady_r <= (state_nxt == flr_pkg::FLR_IDLE);
            wrSlot_r <= wrSlot_nxt;
            tickCnt_r <= tickCnt_nxt;
            upTime_r <= upTime_nxt;
            vPeak_r <= vPeak_nxt;
            iPeak_r <= iPeak_nxt;
            hot_r <= hot_nxt;
            fromNvm_r <= fromNvm_r && !commitReq; // see RULE_18
            vendorStatus_r <= status_nxt;
            pwmFaultOff_r <= storeOk; // see RULE_02
            logPresent_r <= nvm.present;
            logLocked_r <= nvm.locked;
        end
    end

    assign cmdReady = cmdReady_r;
    assign rdValid = rdValid_r;
    assign rdData = rdData_r;
    assign rdLast = rdLast_r;
    assign vendorStatusFlags = vendorStatus_r;
    assign pwmFaultOff = pwmFaultOff_r;
    assign logPresent = logPresent_r;
    assign logLocked = logLocked_r;

    // ==========================================
    // Checks
    a_store_status: assert property ( // see RULE_09
        @(posedge core_clk) disable iff (!arst_n)
        storeCmd && !hot_r && logEnable |=> vendorStatus_r[`FLR_STAT_STORE_BIT]
    ) else $error("forced store did not set status bit");
    a_hot_block: assert property ( // see RULE_10
        @(posedge core_clk) disable iff (!arst_n)
        storeCmd && hot_r && !faultEvent |-> !nvm.commit ##1 !pwmFaultOff_r
    ) else $error("store taken while hot");
    a_hot_hyst: assert property ( // see RULE_10
        @(posedge core_clk) disable iff (!arst_n)
        ($rose(hot_r) |-> $past(dieTempC) > `FLR_TEMP_OFF_C) and
        ($fell(hot_r) |-> $past(dieTempC) < `FLR_TEMP_ON_C)
    ) else $error("temperature gate outside hysteresis");
    a_erase_clear: assert property ( // see RULE_03
        @(posedge core_clk) disable iff (!arst_n || !retainRst_n)
        eraseCmd |=> !nvm.present && !nvm.locked ##1 !logPresent_r && !logLocked_r
    ) else $error("erase left history or lock");
    a_lock_hold: assert property ( // see RULE_17
        @(posedge core_clk) disable iff (!arst_n)
        nvm.locked && faultEvent && !storeCmd |-> !nvm.commit
    ) else $error("locked history overwritten by fault");
    a_commit_show: assert property ( // see RULE_11
        @(posedge core_clk) disable iff (!arst_n || !retainRst_n)
        nvm.commit |=> nvm.present ##1 logPresent_r
    ) else $error("committed history not readable");
    a_len_empty: assert property ( // see RULE_04
        @(posedge core_clk) disable iff (!arst_n)
        state_r == flr_pkg::FLR_LEN && fifoPush && !nvm.present |=>
            state_r == flr_pkg::FLR_IDLE && $past(fifoIn) == 9'h100
    ) else $error("empty history answered nonzero length");
    a_len_full: assert property ( // see RULE_05
        @(posedge core_clk) disable iff (!arst_n)
        state_r == flr_pkg::FLR_DATA && fifoPush && fifoIn[8] |->
            byteIdx_r == `FLR_LAST_IDX ##1 state_r == flr_pkg::FLR_IDLE
    ) else $error("block did not end at byte 146");
    a_byte_order: assert property ( // see RULE_19
        @(posedge core_clk) disable iff (!arst_n)
        state_r == flr_pkg::FLR_DATA && fifoPush && !fifoIn[8] |=>
            byteIdx_r == $past(byteIdx_r) + 8'h01
    ) else $error("readout bytes not ascending");
    a_uptime_step: assert property ( // see RULE_14
        @(posedge core_clk) disable iff (!arst_n)
        tick |=> upTime_r == $past(upTime_r) + 48'h1 ##1 upTime_r == $past(upTime_r)
    ) else $error("uptime did not step once per tick");
    a_page_repeat: assert property ( // see RULE_18
        @(posedge core_clk) disable iff (!arst_n)
        fromNvm_r && state_r == flr_pkg::FLR_DATA && pageIdx_r > `FLR_PAGE_KEEP |->
            nvm.rdPage == `FLR_PAGE_KEEP
    ) else $error("late page not repeated from fourth");
    a_vpeak_track: assert property ( // see RULE_15
        @(posedge core_clk) disable iff (!arst_n)
        vPeakUp && !peakClear |=> vPeak_r == $past(voutReading)
    ) else $error("voltage peak not captured");
endmodule

//--- flr_host_model.sv
// Host model: issues send-byte and block-read commands, collects blocks
// Assumes the logger's command and readout ports on core_clk
`timescale 1ns/1ps
`include "flr_defines.svh"
module flr_host_model (
    // Clock
    input wire logic core_clk,
    // Command
    output logic cmdValid,
    output logic [7:0] cmdCode,
    output logic cmdRead,
    input wire logic cmdReady,
    // Readout
    input wire logic rdValid,
    input wire logic [7:0] rdData,
    input wire logic rdLast,
    output logic rdReady
);
    // ========================================
    // Request and collection
    logic slow = 1'b0;
    logic [7:0] blk [0:147];
    int nGot = 0;
    int lastAt = -1;
    initial begin
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        cmdRead = 1'b0;
        rdReady = 1'b0;
    end
    always @(posedge core_clk) begin
        if (rdValid === 1'b1 && rdReady === 1'b1) begin
            if (nGot < 148) blk[nGot] = rdData;
            if (rdLast === 1'b1 && lastAt < 0) lastAt = nGot;
            nGot = nGot + 1;
        end
        #1 rdReady <= slow ? ~rdReady : 1'b1;
    end
    // Request held until taken, code scrambled after release
    task automatic send(input logic [7:0] code, input logic rd);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdRead <= rd;
        @(posedge core_clk);
        while (cmdReady !== 1'b1) @(posedge core_clk);
        #1 cmdValid <= 1'b0;
        cmdCode <= ~code;
    endtask
    task automatic read_block();
        nGot = 0;
        lastAt = -1;
        send(`FLR_CMD_READOUT, 1'b1);
        repeat (1000) if (lastAt < 0) @(posedge core_clk);
        @(posedge core_clk);
        #1;
    endtask
endmodule

//--- tb_top.sv
// Self-checking bench of the fault history logger
// Assumes the host model drives the command and readout ports
`timescale 1ns/1ps
`include "flr_defines.svh"
module tb_top;
    // ========================================
    // Stimulus and checking
    typedef struct packed {
        logic [7:0] code, temp, cfg;
        logic pwm, stat, pres;
    } flr_tb_row_type;
    logic core_clk = 0, arst_n = 0, retainRst_n = 0, faultEvent = 0, pageDone = 0;
    logic peakClear = 0, statusClear = 0;
    logic [7:0] faultCode = 0, dieTempC = 8'h19, configAll = 8'h80;
    logic [15:0] voutReading = 0, ioutReading = 0;
    logic cmdValid, cmdRead, cmdReady, rdValid, rdLast, rdReady, pwmFaultOff, logPresent;
    logic logLocked;
    logic [7:0] cmdCode, rdData, vendorStatusFlags;
    int n_mismatch = 0, num_checks = 0;
    flr_tb_row_type rows [7] = '{'{8'hEA, 8'h19, 8'h80, 1, 1, 1}, '{8'hEA, 8'h19, 8'h00, 1, 0, 1},
        '{8'hEA, 8'h83, 8'h80, 0, 0, 1}, '{8'hEA, 8'h7F, 8'h80, 0, 0, 1},
        '{8'hEA, 8'h7C, 8'h80, 1, 1, 1}, '{8'h55, 8'h7C, 8'h80, 0, 0, 1},
        '{8'hEC, 8'h7C, 8'h80, 0, 0, 0}};
    always #12.5 core_clk = ~core_clk;
    flr_host_model HOST (.core_clk(core_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdRead(cmdRead), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
        .rdLast(rdLast), .rdReady(rdReady));
    flr_capture_readout #(.TICK_CYCLES(4), .FIFO_DEPTH(4)) DUT (.core_clk(core_clk),
        .arst_n(arst_n), .retainRst_n(retainRst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdRead(cmdRead), .cmdReady(cmdReady), .rdValid(rdValid), .rdData(rdData),
        .rdLast(rdLast), .rdReady(rdReady), .faultEvent(faultEvent), .faultCode(faultCode),
        .pageDone(pageDone), .voutReading(voutReading), .ioutReading(ioutReading),
        .peakClear(peakClear), .dieTempC(dieTempC), .configAll(configAll),
        .statusClear(statusClear), .vendorStatusFlags(vendorStatusFlags),
        .pwmFaultOff(pwmFaultOff), .logPresent(logPresent), .logLocked(logLocked));
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check_block(input logic afterRst);
        chk(8'(HOST.lastAt), `FLR_LOG_LEN);
        chk(HOST.blk[0], `FLR_LOG_LEN);
        chk(HOST.blk[1], 8'h42);
        chk(HOST.blk[7], 8'h00);
        chk(HOST.blk[8], 8'h10);
        chk(HOST.blk[9], 8'h05);
        chk(HOST.blk[10] | HOST.blk[11], 8'h00);
        chk(HOST.blk[12], 8'h08);
        chk(HOST.blk[13], 8'h05);
        for (int p = 0; p < 6; p++) begin
            chk(HOST.blk[28 + 20 * p], 8'h10);
            if (!afterRst) chk(HOST.blk[29 + 20 * p], 8'(5 - p));
            else if (p > 3) chk(HOST.blk[29 + 20 * p], HOST.blk[89]);
        end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        #1 arst_n <= 1'b1;
        retainRst_n <= 1'b1;
        step();
        HOST.read_block();
        chk(8'(HOST.lastAt), 8'h00);
        chk(HOST.blk[0], 8'h00);
        foreach (rows[i]) begin
            dieTempC <= rows[i].temp;
            configAll <= rows[i].cfg;
            repeat (3) step();
            HOST.send(rows[i].code, 1'b0);
            chk({7'h0, pwmFaultOff}, {7'h0, rows[i].pwm});
            chk(vendorStatusFlags, {4'h0, rows[i].stat, 3'h0});
            step();
            chk({7'h0, logPresent}, {7'h0, rows[i].pres});
            statusClear <= 1'b1;
            step();
            statusClear <= 1'b0;
        end
        for (int p = 0; p < 6; p++) begin
            voutReading <= 16'(16'h1000 + p);
            ioutReading <= 16'(16'h0800 + p);
            pageDone <= 1'b1;
            step();
            pageDone <= 1'b0;
            step();
        end
        for (int f = 0; f < 2; f++) begin
            faultCode <= 8'(8'h42 + f);
            faultEvent <= 1'b1;
            step();
            faultEvent <= 1'b0;
            repeat (3) step();
            chk({7'h0, logLocked}, 8'h01);
            HOST.slow = (f == 0);
            HOST.read_block();
            check_block(1'b0);
        end
        arst_n <= 1'b0;
        step();
        chk({7'h0, cmdReady}, 8'h01);
        arst_n <= 1'b1;
        repeat (3) step();
        chk({7'h0, logPresent}, 8'h01);
        HOST.read_block();
        check_block(1'b1);
        HOST.send(`FLR_CMD_ERASE, 1'b0);
        step();
        HOST.read_block();
        chk(HOST.blk[0], 8'h00);
        {pageDone, peakClear} <= 2'b11;
        step();
        {pageDone, peakClear} <= 2'b00;
        HOST.send(`FLR_CMD_STORE, 1'b0);
        step();
        HOST.read_block();
        chk(HOST.blk[1], `FLR_STORE_CODE);
        chk(HOST.blk[8] | HOST.blk[12], 8'h00);
        print_verdict();
    end
    initial begin
        #500000;
        n_mismatch++;
        print_verdict();
    end
endmodule
